// file: sim/ulmsd_modem_model.sv
// Data set model: drives the serial line and the active-low modem inputs.
`timescale 1ns/1ps
module ulmsd_modem_model (
    // Clock.
    input  wire logic       clk,
    // Serial lines and modem inputs, all idle high.
    output logic            rxd,
    output logic            txSerial,
    output logic      [3:0] modemN
);
    logic ln   = 1'b1;
    logic toTx = 1'b0;

    // Only the chosen line carries the frame; the other one idles high.
    assign rxd      = toTx ? 1'b1 : ln;
    assign txSerial = toTx ? ln : 1'b1;

    // Modem inputs start inactive so no change is seen at reset release.
    initial modemN = 4'hf;

    // Start, eight data bits, optional parity, one stop; 16 clocks a bit.
    task automatic frame(input logic [7:0] d, input logic p, useP, stp, onTx);
        logic [10:0] s;
        int          n;
        s = {stp, p, d, 1'b0};
        n = useP ? 11 : 10;
        if (!useP) s[9] = stp;
        @(posedge clk);
        toTx <= onTx;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            ln <= s[i];
            repeat (15) @(posedge clk);
        end
        @(posedge clk);
        ln <= 1'b1;
        repeat (31) @(posedge clk);
    endtask

    // Holds the line low for longer than a frame, then releases it.
    task automatic holdLow(input int c);
        @(posedge clk);
        ln <= 1'b0;
        repeat (c) @(posedge clk);
        ln <= 1'b1;
        repeat (32) @(posedge clk);
    endtask

    // A new modem level is held long enough for any delta to settle.
    task automatic setModem(input logic [3:0] v);
        @(posedge clk);
        modemN <= v;
        repeat (8) @(posedge clk);
    endtask
endmodule

// file: sim/ulmsd_regs_monitor.sv
// Concurrent checks on the ports of the register block.
`timescale 1ns/1ps
module ulmsd_regs_monitor
    import ulmsd_pkg::*;
(
    // Clock and reset.
    input wire logic       clk,
    input wire logic       rstn,
    // Host register port.
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    // Serial line, transmitter and modem.
    input wire logic       rxd,
    input wire logic       txSerial,
    input wire logic       txHoldEmpty,
    input wire logic       txShiftEmpty,
    input wire logic       txWrite,
    input wire logic [7:0] txData,
    input wire logic       txEmptyIrq,
    input wire logic       baudTick,
    input wire logic       carrierDetectInN,
    input wire logic       ringIndicatorInN,
    input wire logic       dataSetReadyInN,
    input wire logic       clearToSendInN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    wire logic [3:0] mIn = {carrierDetectInN, ringIndicatorInN, dataSetReadyInN, clearToSendInN};
    logic      [3:0] modemQ;
    logic      [2:0] quietQ;

    // Quiet cycles since the last modem change or write; a delta may lag a change.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modemQ <= 4'hf;
            quietQ <= 3'h0;
        end else begin
            modemQ <= mIn;
            quietQ <= (mIn != modemQ || regWrite) ? 3'h0 : quietQ + {2'h0, quietQ != 3'h7};
        end
    end

    // Read data of a line status read stand one cycle after the strobe.
    sequence s_line_rd;
        $past(regRead) && $past(regAddr) == OFF_LINE_STATUS;
    endsequence
    sequence s_modem_rd;
        regRead && regAddr == OFF_MODEM_STAT;
    endsequence

    property p_both;
        s_line_rd |-> regRdData[6] == ($past(txHoldEmpty) && $past(txShiftEmpty));
    endproperty
    property p_hold;
        s_line_rd |-> regRdData[5] == $past(txHoldEmpty);
    endproperty
    property p_irq; txEmptyIrq |-> $past(txHoldEmpty); endproperty
    property p_err;
        s_line_rd ##0 regRdData[4:2] != 3'h0 |-> regRdData[7] && regRdData[0];
    endproperty
    // With nothing held, of bits 7..2 only the two transmitter bits may be set.
    property p_none;
        s_line_rd ##0 !regRdData[0] |-> regRdData[7:2] == (6'h18 & regRdData[7:2]);
    endproperty
    property p_clr;
        s_modem_rd ##[1:2] (s_modem_rd ##0 quietQ == 3'h7) |=> regRdData[3:0] == 4'h0;
    endproperty
    property p_txw;
        txWrite |-> $past(regWrite) && $past(regAddr) == OFF_RX_TX;
    endproperty
    property p_txd; txWrite |-> txData == $past(regWrData); endproperty

    a_both: assert property (p_both) else $error("bit 6 not both empties");
    a_hold: assert property (p_hold) else $error("bit 5 not holding empty");
    a_irq: assert property (p_irq) else $error("irq while holding busy");
    a_err: assert property (p_err) else $error("head error without bit 7");
    a_none: assert property (p_none) else $error("error bits with no data");
    a_clr: assert property (p_clr) else $error("deltas survive a read");
    a_txw: assert property (p_txw) else $error("stray transmit write");
    a_txd: assert property (p_txd) else $error("wrong transmit data");
endmodule

bind ulmsd_regs ulmsd_regs_monitor ulmsd_regs_monitor_inst (.*);

// file: sim/ulmsd_regs_tb_top.sv
// Testbench of the line, modem status and divisor register block.
`timescale 1ns/1ps
module ulmsd_regs_tb_top;
    import ulmsd_pkg::*;
    logic            clk          = 1'b0;
    logic            rstn         = 1'b0;
    logic      [2:0] regAddr      = 3'h0;
    logic      [7:0] regWrData    = 8'h00;
    logic            regWrite     = 1'b0;
    logic            regRead      = 1'b0;
    logic            txHoldEmpty  = 1'b1;
    logic            txShiftEmpty = 1'b1;
    logic      [7:0] regRdData, txData, got;
    logic            txWrite, txEmptyIrq, baudTick;
    logic     [15:0] gap;
    wire logic       rxd, txSerial;
    wire logic [3:0] modemN;
    int              n_errors     = 0;
    int              tests_run    = 0;

    // 40 MHz clock.
    always #12.5 clk = ~clk;

    ulmsd_regs ulmsd_regs_inst (.*, .carrierDetectInN(modemN[3]), .ringIndicatorInN(modemN[2]),
        .dataSetReadyInN(modemN[1]), .clearToSendInN(modemN[0]));
    ulmsd_modem_model ulmsd_modem_model_inst (.*);

    task automatic test_done();
        $display("tests %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One-cycle strobes; a task returns after the edge that takes it.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        cyc(1);
        regWrite  <= 1'b0;
    endtask

    // Read data stand only in the cycle after the read edge.
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        cyc(1);
        regRead <= 1'b0;
        got = regRdData;
        chk({8'h00, got}, {8'h00, e});
    endtask

    // Cycles from one baud tick to the next; both waits are bounded.
    task automatic tickGap();
        int i;
        i   = 0;
        gap = 16'h0;
        while (baudTick !== 1'b1 && i < 1000) begin
            cyc(1);
            i++;
        end
        do begin
            cyc(1);
            gap++;
        end while (baudTick !== 1'b1 && gap < 16'd1000);
        if (i >= 1000 || gap >= 16'd1000) begin
            n_errors++;
            $display("MISMATCH %0t baud tick never came", $time);
            test_done();
        end
    endtask

    //--------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rdc(3'h5, 8'h60);
        rdc(3'h6, 8'h00);
        // Transmitter flags and the holding-empty interrupt.
        txShiftEmpty <= 1'b0;
        rdc(3'h5, 8'h20);
        txHoldEmpty <= 1'b0;
        rdc(3'h5, 8'h00);
        wr(3'h1, 8'h02);
        txHoldEmpty <= 1'b1;
        cyc(2);
        chk({15'h0, txEmptyIrq}, 16'h1);
        txHoldEmpty <= 1'b0;
        cyc(2);
        chk({15'h0, txEmptyIrq}, 16'h0);
        txHoldEmpty  <= 1'b1;
        txShiftEmpty <= 1'b1;
        wr(3'h7, 8'ha5);
        rdc(3'h7, 8'ha5);
        wr(3'h0, 8'h3c);
        chk({7'h0, txWrite, txData}, 16'h013c);
        // Each modem input active then inactive; ring sets its delta on release only.
        for (int i = 0; i < 4; i++) begin
            ulmsd_modem_model_inst.setModem(4'hf ^ (4'h1 << i));
            rdc(3'h6, (8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i));
            rdc(3'h6, 8'h10 << i);
            ulmsd_modem_model_inst.setModem(4'hf);
            rdc(3'h6, 8'h01 << i);
        end
        // Loopback: modem control into modem status, transmit into receive.
        wr(3'h3, 8'h03);
        wr(3'h4, 8'h1a);
        cyc(3);
        rdc(3'h6, 8'h99);
        rdc(3'h6, 8'h90);
        wr(3'h4, 8'h15);
        cyc(3);
        rdc(3'h6, 8'h6b);
        rdc(3'h6, 8'h60);
        ulmsd_modem_model_inst.frame(8'h3c, 1'b0, 1'b0, 1'b1, 1'b1);
        rdc(3'h0, 8'h3c);
        wr(3'h4, 8'h00);
        // A clean character; status reads never pop it.
        ulmsd_modem_model_inst.frame(8'h5a, 1'b0, 1'b0, 1'b1, 1'b0);
        rdc(3'h5, 8'h61);
        rdc(3'h5, 8'h61);
        rdc(3'h0, 8'h5a);
        rdc(3'h5, 8'h60);
        // Even parity wrong, then odd parity right, for the same bits.
        wr(3'h3, 8'h1b);
        ulmsd_modem_model_inst.frame(8'h01, 1'b0, 1'b1, 1'b1, 1'b0);
        rdc(3'h5, 8'he5);
        rdc(3'h0, 8'h01);
        rdc(3'h5, 8'h60);
        wr(3'h3, 8'h0b);
        ulmsd_modem_model_inst.frame(8'h01, 1'b0, 1'b1, 1'b1, 1'b0);
        rdc(3'h5, 8'h61);
        rdc(3'h0, 8'h01);
        // Missing stop bit.
        wr(3'h3, 8'h03);
        ulmsd_modem_model_inst.frame(8'hff, 1'b0, 1'b0, 1'b0, 1'b0);
        rdc(3'h5, 8'he9);
        rdc(3'h0, 8'hff);
        rdc(3'h5, 8'h60);
        // A long break in FIFO mode stores one character.
        wr(3'h2, 8'h01);
        ulmsd_modem_model_inst.holdLow(400);
        rdc(3'h5, 8'hf9);
        rdc(3'h0, 8'h00);
        rdc(3'h5, 8'h60);
        // Overrun with a single-character store keeps the first character.
        wr(3'h2, 8'h00);
        ulmsd_modem_model_inst.frame(8'h11, 1'b0, 1'b0, 1'b1, 1'b0);
        ulmsd_modem_model_inst.frame(8'h22, 1'b0, 1'b0, 1'b1, 1'b0);
        rdc(3'h5, 8'h63);
        rdc(3'h5, 8'h61);
        rdc(3'h0, 8'h11);
        // Divisor page, written before sleep and never to zero.
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h03);
        chk({15'h0, txWrite}, 16'h0);
        wr(3'h1, 8'h00);
        rdc(3'h0, 8'h03);
        tickGap();
        chk(gap, 16'h3);
        wr(3'h1, 8'h01);
        rdc(3'h1, 8'h01);
        tickGap();
        chk(gap, 16'h103);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h10);
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h05);
        rdc(3'h0, 8'h03);
        test_done();
    end
endmodule

// file: verilog/ulmsd_pkg.sv
// Constants, field positions and types of the line, modem status and divisor register block.
//------------------------------------------------------------------------------
// Functional notes
// - Line status bits 4..2 show break, framing, parity of the receive head character.
// - Reading line status never pops; only a receive buffer read advances the head.
// - Line status bit 7 is set while any held character carries an error.
// - Line status bit 6 reads 1 only when holding and shift registers are both empty.
// - Line status bit 5 shows holding empty and requests interrupt when enabled.
// - Bit 4 flags a break after one all-low frame; only one character stored.
// - Bit 3 flags a framing error when the stop bit is not high.
// - Bit 2 flags a parity error against the parity type chosen in line control.
// - Bit 1 flags overrun when a character arrives with no room; it is discarded.
// - Bit 0 reads 1 while at least one received character is held.
// - Modem status low bits set on input change and clear when modem status is read.
// - Outside loopback modem status bits 7..4 are inverted carrier, ring, set ready, send inputs.
// - In loopback bits 7..4 show aux output two, aux output one, DTR, RTS.
// - Modem status bit 2 sets only on a low to high ring indicator input.
// - Modem status bits 3, 1, 0 set on any change of carrier, set ready, send.
// - An 8-bit scratch register stores host data and steers nothing.
// - The divisor is 16 bits from a high and a low 8-bit latch.
// - Divisor latches are writable only while sleep enable is clear.
// - The divisor latch page is reached only while divisor latch enable is set.
// - Loopback routes modem control into modem status and transmit into receive.
//------------------------------------------------------------------------------
package ulmsd_pkg;

    // Register offsets; page one shares offsets 0 and 1 with page zero.
    localparam logic [2:0] OFF_RX_TX       = 3'h0;
    localparam logic [2:0] OFF_DIV_LOW     = 3'h0;
    localparam logic [2:0] OFF_INT_ENABLE  = 3'h1;
    localparam logic [2:0] OFF_DIV_HIGH    = 3'h1;
    localparam logic [2:0] OFF_FIFO_CTRL   = 3'h2;
    localparam logic [2:0] OFF_LINE_CTRL   = 3'h3;
    localparam logic [2:0] OFF_MODEM_CTRL  = 3'h4;
    localparam logic [2:0] OFF_LINE_STATUS = 3'h5;
    localparam logic [2:0] OFF_MODEM_STAT  = 3'h6;
    localparam logic [2:0] OFF_SCRATCH     = 3'h7;

    // Field positions.
    localparam int LC_DIV_EN   = 7;
    localparam int LC_STICK    = 5;
    localparam int LC_EVEN     = 4;
    localparam int LC_PAR_EN   = 3;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_SLEEP    = 4;
    localparam int MC_LOOP     = 4;
    localparam int MC_AUX_TWO  = 3;
    localparam int MC_AUX_ONE  = 2;
    localparam int MC_RTS      = 1;
    localparam int MC_DTR      = 0;
    localparam int FC_FIFO_EN  = 0;
    localparam int FC_RX_RESET = 1;

    // Reset values.
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [15:0] DIVISOR_RST = 16'h0001;

    // Receive store and oversampling.
    localparam int          FIFO_DEPTH  = 16;
    localparam logic [4:0]  DEPTH_FIFO  = 5'h10;
    localparam logic [4:0]  DEPTH_PLAIN = 5'h01;
    localparam logic [3:0]  TICK_MID    = 4'h7;
    localparam logic [3:0]  TICK_LAST   = 4'hf;
    localparam logic [2:0]  BITS_MIN    = 3'h4;

    typedef struct packed {
        logic       brk;
        logic       frameErr;
        logic       parErr;
        logic [7:0] data;
    } ulmsd_char_t;

    typedef enum logic [5:0] {
        RX_IDLE  = 6'b000001,
        RX_START = 6'b000010,
        RX_DATA  = 6'b000100,
        RX_PAR   = 6'b001000,
        RX_STOP  = 6'b010000,
        RX_BRK   = 6'b100000
    } ulmsd_rx_t;

    typedef struct packed {
        logic [7:0]                       lineCtrl;
        logic [7:0]                       modemCtrl;
        logic [7:0]                       intEnable;
        logic                             fifoEn;
        logic [7:0]                       scratch;
        logic [15:0]                      divisor;
        logic [15:0]                      baudCnt;
        logic                             tick;
        ulmsd_rx_t                        rxSt;
        logic [3:0]                       rxTick;
        logic [2:0]                       rxBit;
        logic [7:0]                       rxShift;
        logic                             rxPar;
        logic [FIFO_DEPTH-1:0][10:0]      mem;
        logic [3:0]                       wrPtr;
        logic [3:0]                       rdPtr;
        logic [4:0]                       count;
        logic [4:0]                       errCount;
        logic                             overrun;
        logic [3:0]                       modemUpper;
        logic [3:0]                       modemDelta;
        logic [7:0]                       rdData;
        logic                             txWrite;
        logic [7:0]                       txData;
        logic                             txIrq;
    } ulmsd_state_t;

endpackage

// file: verilog/ulmsd_regs.sv
// Line status, modem status, scratch and divisor register block of one serial channel.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module ulmsd_regs
    import ulmsd_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rstn,
    // Host register port.
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    // Serial line and transmitter status.
    input  wire logic       rxd,
    input  wire logic       txSerial,
    input  wire logic       txHoldEmpty,
    input  wire logic       txShiftEmpty,
    output logic            txWrite,
    output logic      [7:0] txData,
    output logic            txEmptyIrq,
    output logic            baudTick,
    // Modem inputs, active low.
    input  wire logic       carrierDetectInN,
    input  wire logic       ringIndicatorInN,
    input  wire logic       dataSetReadyInN,
    input  wire logic       clearToSendInN
);

    ulmsd_state_t q;
    ulmsd_state_t d;

    logic        page1;
    logic        loopback;
    logic        rxIn;
    logic [3:0]  upperNow;
    logic [3:0]  deltaSet;
    logic [2:0]  lastBit;
    logic        expPar;
    logic        push;
    ulmsd_char_t pushChar;
    ulmsd_char_t head;
    logic        headErr;
    logic        empty;
    logic        full;
    logic        pop;
    logic        lineRead;
    logic        modemRead;
    logic        rxReset;
    logic        cntInc;
    logic        cntDec;
    logic        errInc;
    logic        errDec;
    logic        ovSet;
    logic [7:0]  lineValue;

    //--------------------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------------------

    // All behaviour is worked out here from the registered state and the live inputs.
    always_comb begin
        d        = q;
        d.txWrite = 1'b0;
        d.rdData  = 8'h00;
        page1    = q.lineCtrl[LC_DIV_EN];
        loopback = q.modemCtrl[MC_LOOP];
        rxIn     = loopback ? txSerial : rxd;
        push     = 1'b0;
        pushChar = '0;
        pop      = 1'b0;
        lineRead = 1'b0;
        modemRead = 1'b0;
        rxReset  = 1'b0;
        ovSet    = 1'b0;
        lastBit  = 3'(BITS_MIN + {1'b0, q.lineCtrl[1:0]});
        empty    = (q.count == 5'h00);
        full     = q.count >= (q.fifoEn ? DEPTH_FIFO : DEPTH_PLAIN);
        head     = empty ? ulmsd_char_t'('0) : ulmsd_char_t'(q.mem[q.rdPtr]);
        headErr  = head.brk | head.frameErr | head.parErr;

        // Odd parity wants an odd total, even an even one; stick forces a level.
        if (q.lineCtrl[LC_STICK]) begin
            expPar = ~q.lineCtrl[LC_EVEN];
        end else begin
            expPar = q.lineCtrl[LC_EVEN] ? (^q.rxShift) : ~(^q.rxShift);
        end

        // Modem status upper bits: live inputs or the looped control bits.
        if (loopback) begin
            upperNow = {q.modemCtrl[MC_AUX_TWO], q.modemCtrl[MC_AUX_ONE],
                        q.modemCtrl[MC_DTR], q.modemCtrl[MC_RTS]};
        end else begin
            upperNow = ~{carrierDetectInN, ringIndicatorInN,
                         dataSetReadyInN, clearToSendInN};
        end
        deltaSet[3] = q.modemUpper[3] ^ upperNow[3];
        deltaSet[2] = q.modemUpper[2] & ~upperNow[2];
        deltaSet[1] = q.modemUpper[1] ^ upperNow[1];
        deltaSet[0] = q.modemUpper[0] ^ upperNow[0];
        d.modemUpper = upperNow;

        // Sixteen-times baud enable; a zero divisor degrades to every cycle.
        d.tick    = (q.baudCnt + 16'h0001) >= q.divisor;
        d.baudCnt = d.tick ? 16'h0000 : q.baudCnt + 16'h0001;

        // Receiver: mid-bit sampling with the sixteen-times enable.
        if (q.tick) begin
            d.rxTick = q.rxTick + 4'h1;
            unique case (q.rxSt)
                RX_IDLE: begin
                    d.rxTick = 4'h0;
                    if (!rxIn) begin
                        d.rxSt = RX_START;
                    end
                end
                RX_START: begin
                    if (q.rxTick == TICK_MID) begin
                        d.rxTick  = 4'h0;
                        d.rxBit   = 3'h0;
                        d.rxShift = 8'h00;
                        d.rxPar   = 1'b0;
                        d.rxSt    = rxIn ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (q.rxTick == TICK_LAST) begin
                        d.rxShift[q.rxBit] = rxIn;
                        d.rxBit = q.rxBit + 3'h1;
                        if (q.rxBit == lastBit) begin
                            d.rxSt = q.lineCtrl[LC_PAR_EN] ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (q.rxTick == TICK_LAST) begin
                        d.rxPar = rxIn;
                        d.rxSt  = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (q.rxTick == TICK_LAST) begin
                        push          = 1'b1;
                        pushChar.data = q.rxShift;
                        pushChar.frameErr = ~rxIn;
                        pushChar.parErr   = q.lineCtrl[LC_PAR_EN] && (q.rxPar != expPar);
                        // A frame low from start to stop is a break.
                        pushChar.brk  = (q.rxShift == 8'h00) && !rxIn && !q.rxPar;
                        d.rxSt        = pushChar.brk ? RX_BRK : RX_IDLE;
                    end
                end
                RX_BRK: begin
                    // Hold off until the line idles so one break stores one character.
                    if (rxIn) begin
                        d.rxSt = RX_IDLE;
                    end
                end
            endcase
        end

        // Host writes.
        if (regWrite) begin
            unique case (regAddr)
                OFF_RX_TX: begin
                    if (page1) begin
                        if (!q.intEnable[IE_SLEEP]) begin
                            d.divisor[7:0] = regWrData;
                        end
                    end else begin
                        d.txWrite = 1'b1;
                        d.txData  = regWrData;
                    end
                end
                OFF_INT_ENABLE: begin
                    if (page1) begin
                        if (!q.intEnable[IE_SLEEP]) begin
                            d.divisor[15:8] = regWrData;
                        end
                    end else begin
                        d.intEnable = regWrData;
                    end
                end
                OFF_FIFO_CTRL: begin
                    d.fifoEn = regWrData[FC_FIFO_EN];
                    // Changing depth mid-stream would scramble pointers, so flush.
                    rxReset  = regWrData[FC_RX_RESET] ||
                               (regWrData[FC_FIFO_EN] != q.fifoEn);
                end
                OFF_LINE_CTRL:   d.lineCtrl  = regWrData;
                OFF_MODEM_CTRL:  d.modemCtrl = regWrData;
                OFF_SCRATCH:     d.scratch   = regWrData;
                default: begin
                end
            endcase
        end

        // Line status image.
        lineValue = {(q.errCount != 5'h00),
                    txHoldEmpty & txShiftEmpty,
                    txHoldEmpty,
                    head.brk, head.frameErr, head.parErr,
                    q.overrun,
                    !empty};

        // Host reads; data stands in the following cycle only.
        if (regRead) begin
            unique case (regAddr)
                OFF_RX_TX: begin
                    if (page1) begin
                        d.rdData = q.divisor[7:0];
                    end else begin
                        d.rdData = head.data;
                        pop      = !empty;
                    end
                end
                OFF_INT_ENABLE: d.rdData = page1 ? q.divisor[15:8] : q.intEnable;
                OFF_FIFO_CTRL:  d.rdData = 8'h00;
                OFF_LINE_CTRL:  d.rdData = q.lineCtrl;
                OFF_MODEM_CTRL: d.rdData = q.modemCtrl;
                OFF_LINE_STATUS: begin
                    d.rdData = lineValue;
                    lineRead = 1'b1;
                end
                OFF_MODEM_STAT: begin
                    d.rdData  = {q.modemUpper, q.modemDelta};
                    modemRead = 1'b1;
                end
                OFF_SCRATCH:    d.rdData = q.scratch;
                default: begin
                end
            endcase
        end

        // A change seen in the read cycle survives the clear.
        d.modemDelta = (modemRead ? 4'h0 : q.modemDelta) | deltaSet;

        // Receive store: a character arriving with no room is dropped.
        if (push && full) begin
            ovSet = 1'b1;
        end
        cntInc = push && !full;
        if (cntInc) begin
            d.mem[q.wrPtr] = 11'(pushChar);
            d.wrPtr        = q.wrPtr + 4'h1;
        end
        cntDec = pop;
        if (pop) begin
            d.rdPtr = q.rdPtr + 4'h1;
        end
        // A line status read retires the head character's error marks.
        if (lineRead && !empty) begin
            d.mem[q.rdPtr][10:8] = 3'h0;
        end
        errInc = cntInc && (pushChar.brk | pushChar.frameErr | pushChar.parErr);
        errDec = (pop || lineRead) && headErr;
        d.count    = 5'(q.count + {4'h0, cntInc} - {4'h0, cntDec});
        d.errCount = 5'(q.errCount + {4'h0, errInc} - {4'h0, errDec});
        d.overrun  = (q.overrun && !lineRead) || ovSet;

        // Flushing the store drops its error accounting with it.
        if (rxReset) begin
            d.wrPtr    = 4'h0;
            d.rdPtr    = 4'h0;
            d.count    = 5'h00;
            d.errCount = 5'h00;
        end

        // Registered holding-empty request.
        d.txIrq = txHoldEmpty & q.intEnable[IE_TX_EMPTY];
    end

    //--------------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------------

    // The whole block state in one register; reset loads constants only.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q           <= '0;
            q.lineCtrl  <= CTRL_RST;
            q.modemCtrl <= CTRL_RST;
            q.intEnable <= CTRL_RST;
            q.divisor   <= DIVISOR_RST;
            q.rxSt      <= RX_IDLE;
        end else begin
            q <= d;
        end
    end

    // Outputs taken straight from the state register.
    assign regRdData  = q.rdData;
    assign txWrite    = q.txWrite;
    assign txData     = q.txData;
    assign txEmptyIrq = q.txIrq;
    assign baudTick   = q.tick;

endmodule
